// ==== bench/sadc_afe_model.sv ====
// analog front end model: fixed level per input and comparator
`timescale 1ns/1ps

module sadc_afe_model (
    input wire logic afe_power,
    input wire logic [16:0] afe_input_select,
    input wire logic [11:0] afe_dac_code,
    output logic afe_compare
);
    logic [11:0] level;
    always_comb begin
        // nothing routed reads as ground, so a reserved code converts to zero
        level = 12'h000;
        for (int i = 0; i < 17; i++) begin
            if (afe_input_select[i]) begin
                level = 12'h123 + 12'(i) * 12'h0F1;
            end
        end
        afe_compare = afe_power && level >= afe_dac_code;
    end
endmodule : sadc_afe_model

// ==== bench/sadc_checker.sv ====
// assertion checker for the converter control block
`timescale 1ns/1ps
`include "sadc_defs.svh"

module sadc_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic afe_power,
    input wire logic [16:0] afe_input_select,
    input wire logic [1:0] afe_reference_select,
    input wire logic afe_sample,
    input wire logic irq
);
    localparam logic [31:0] A_CTL = {22'h000000, `SADC_IDX_CONTROL, 2'b00};
    localparam logic [31:0] A_CFG = {22'h000000, `SADC_IDX_CONFIG, 2'b00};
    localparam logic [31:0] A_ST = {22'h000000, `SADC_IDX_STATUS, 2'b00};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic dp_v;
    logic dp_w;
    logic [31:0] dp_a;
    logic [9:0] smp_len;
    logic [9:0] cnv_len;
    // data phase of the transfer that completes at this edge
    wire ctl_wr = dp_v && dp_w && dp_a == A_CTL && hreadyout;
    wire cfg_wr = dp_v && dp_w && dp_a == A_CFG && hreadyout;
    wire st_rd = dp_v && !dp_w && dp_a == A_ST && hreadyout;
    function automatic logic [16:0] chan_hot(input logic [4:0] c);
        chan_hot = c == 5'h1F ? 17'h10000 : c[4] ? 17'h00000 : 17'h00001 << c[3:0];
    endfunction : chan_hot
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dp_v <= 1'b0;
        end else if (hreadyout) begin
            dp_v <= hsel && htrans[1] && hready;
        end
        if (hreadyout) begin
            dp_w <= hwrite;
            dp_a <= haddr;
        end
        // cnv_len saturates so a long idle never wraps into a legal figure
        smp_len <= afe_sample ? smp_len + 10'h001 : 10'h000;
        cnv_len <= afe_sample ? 10'h000 : cnv_len + 10'(cnv_len != 10'h3FF);
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_power_follow;
        ctl_wr |=> afe_power == $past(hwdata[7]);
    endproperty
    a_power_follow: assert property (p_power_follow)
        else $error("power bit not followed");
    property p_start;
        ctl_wr && hwdata[7:6] == 2'b11 |=> afe_sample;
    endproperty
    a_start: assert property (p_start)
        else $error("trigger did not start sampling");
    property p_no_start;
        ctl_wr && !hwdata[6] && !afe_sample |=> !afe_sample;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("sampling without trigger");
    property p_chan;
        ctl_wr |=> afe_input_select == chan_hot($past(hwdata[4:0]));
    endproperty
    a_chan: assert property (p_chan)
        else $error("wrong input routed");
    property p_ref;
        cfg_wr |=> afe_reference_select == $past(hwdata[7:6]);
    endproperty
    a_ref: assert property (p_ref)
        else $error("wrong reference routed");
    property p_sample_len;
        $fell(afe_sample) && afe_power |-> smp_len inside {96, 72, 36, 24, 576, 432, 216, 144};
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("sampling length wrong");
    property p_conv_len;
        $rose(irq) |-> cnv_len inside {[56:58], [84:86], [168:170], [224:226]};
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");
    property p_status_clear;
        st_rd |-> ##2 !irq;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status read left interrupt high");
endmodule : sadc_checker

bind sadc_top sadc_checker i_sadc_checker (.*);

// ==== bench/sar_adc_control_bench.sv ====
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "sadc_defs.svh"

module sar_adc_control_bench;
    localparam logic [31:0] A_CTL = {22'h000000, `SADC_IDX_CONTROL, 2'b00};
    localparam logic [31:0] A_CFG = {22'h000000, `SADC_IDX_CONFIG, 2'b00};
    localparam logic [31:0] A_RES = {22'h000000, `SADC_IDX_RESULT, 2'b00};
    localparam logic [31:0] A_ST = {22'h000000, `SADC_IDX_STATUS, 2'b00};
    localparam logic [31:0] A_MSK = {22'h000000, `SADC_IDX_MASK, 2'b00};
    logic core_clk, rst, hsel, hwrite, hreadyout, hresp, afe_compare, afe_power, afe_sample, irq;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans, afe_reference_select;
    logic [16:0] afe_input_select;
    logic [11:0] afe_dac_code, lvl;
    logic [7:0] cfg;
    logic [4:0] chs[5] = '{5'h00, 5'h0E, 5'h0F, 5'h1F, 5'h10};
    logic [31:0] regs[6] = '{A_CTL, A_CFG, A_RES, A_ST, A_MSK, 32'h00000300};
    int bad_count = 0, checked = 0, cyc = 0, t0, s, d;
    sadc_top i_sadc_top (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .afe_compare(afe_compare), .afe_power(afe_power),
        .afe_input_select(afe_input_select), .afe_reference_select(afe_reference_select),
        .afe_sample(afe_sample), .afe_dac_code(afe_dac_code), .irq(irq));
    sadc_afe_model i_sadc_afe_model (.afe_power(afe_power), .afe_input_select(afe_input_select),
        .afe_dac_code(afe_dac_code), .afe_compare(afe_compare));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        checked++;
        if (v !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    // one single transfer; waits on hready with no assumed latency
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dt);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dt;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : ahb
    task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h00000000);
        chk(n, e, rdv);
        chk("response", 32'h00000000, {31'h0, hresp});
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ceiling well above five conversions of at most 800 cycles each
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        foreach (regs[k]) rd("reset value", regs[k], 32'h00000000);
        ahb(1'b1, A_MSK, 32'h00000001);
        ahb(1'b1, A_CTL, 32'h00000043);
        @(posedge core_clk);
        chk("start while off", 32'h0, {31'h0, afe_sample});
        for (int i = 0; i < 5; i++) begin
            cfg = {i[1:0], 3'h0, i[0], i[1:0]};
            d = cfg[1:0] == 2'h0 ? 16 : cfg[1:0] == 2'h1 ? 12 : cfg[1:0] == 2'h2 ? 6 : 4;
            s = cfg[2] ? 36 : 6;
            lvl = chs[i] == 5'h1F ? 12'h123 + 12'h0F1 * 12'h010 : chs[i][4] ? 12'h000 : 12'h123 + 12'h0F1 * chs[i];
            ahb(1'b1, A_CFG, {24'h0, cfg});
            ahb(1'b1, A_CTL, {24'h0, 3'h6, chs[i]});
            t0 = cyc;
            @(posedge core_clk);
            chk("reference", {30'h0, cfg[7:6]}, {30'h0, afe_reference_select});
            chk("sampling", 32'h1, {31'h0, afe_sample});
            rd("done cleared", A_CTL, {24'h0, 3'h4, chs[i]});
            while (irq !== 1'b1 && cyc - t0 < 1500) @(posedge core_clk);
            chk("duration in range", 32'h1, 32'((cyc - t0 - (s + 14) * d) inside {[0:3]}));
            rd("done set", A_CTL, {24'h0, 3'h5, chs[i]});
            rd("result", A_RES, {20'h0, lvl});
            rd("status", A_ST, 32'h00000001);
            rd("status cleared", A_ST, 32'h00000000);
            chk("irq cleared", 32'h0, {31'h0, irq});
            ahb(1'b1, A_CTL, {24'h0, 3'h5, chs[i]});
            @(posedge core_clk);
            chk("zero trigger", 32'h0, {31'h0, afe_sample});
        end
        ahb(1'b1, A_CTL, 32'h000000C3);
        ahb(1'b1, A_CTL, 32'h00000003);
        repeat (400) @(posedge core_clk);
        chk("abort", 32'h0, {31'h0, afe_sample | irq});
        rd("no event", A_ST, 32'h00000000);
        ahb(1'b1, A_MSK, 32'h00000000);
        ahb(1'b1, A_CTL, 32'h000000C3);
        repeat (400) @(posedge core_clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        rd("masked status", A_ST, 32'h00000001);
        stop_test();
    end
endmodule : sar_adc_control_bench

// ==== core/sadc_defs.svh ====
// register map, field positions, reset values and timing counts of the converter control block
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// register indices; byte address is four times the index
`define SADC_IDX_CONFIG 8'hAA
`define SADC_IDX_CONTROL 8'hAD
`define SADC_IDX_RESULT 8'hAE
`define SADC_IDX_STATUS 8'hB0
`define SADC_IDX_MASK 8'hB1

// control register fields
`define SADC_CTL_POWER 7
`define SADC_CTL_TRIGGER 6
`define SADC_CTL_DONE 5
`define SADC_CTL_CHAN_LSB 0
`define SADC_CTL_CHAN_W 5

// config register fields
`define SADC_CFG_DIV_LSB 0
`define SADC_CFG_LONG 2
`define SADC_CFG_REF_LSB 6

// status and mask fields
`define SADC_ST_DONE 0

// reset values
`define SADC_CTL_RESET 8'h00
`define SADC_CFG_RESET 8'h00
`define SADC_MASK_RESET 1'b0

// converter clock counts
`define SADC_SAMPLE_SHORT 6'd6
`define SADC_SAMPLE_LONG 6'd36
`define SADC_CONVERT_CLKS 6'd14
`define SADC_DIV_CODE0 5'd16
`define SADC_DIV_CODE1 5'd12
`define SADC_DIV_CODE2 5'd6
`define SADC_DIV_CODE3 5'd4

// channel codes
`define SADC_CHAN_LAST_PIN 5'h0F
`define SADC_CHAN_QUARTER 5'h1F

`endif

// ==== core/sadc_pkg.sv ====
// types of the converter control block
package sadc_pkg;

    typedef enum logic [2:0] {
        SADC_IDLE = 3'b001,
        SADC_SAMPLE = 3'b010,
        SADC_CONVERT = 3'b100
    } sadc_state_t;

    typedef enum logic [1:0] {
        SADC_REF_SUPPLY = 2'b00,
        SADC_REF_1V024 = 2'b01,
        SADC_REF_2V4 = 2'b10,
        SADC_REF_2V048 = 2'b11
    } sadc_ref_t;

endpackage : sadc_pkg

// ==== core/sadc_top.sv ====
// successive-approximation converter control with an AHB-Lite register slave
// What this block does
// RULE1 - control top bit powers converter on or off
// RULE2 - trigger bit only starts; zero does nothing
// RULE3 - starting a conversion clears the done flag
// RULE4 - finished conversion sets done; zero means pending
// RULE5 - software clears done flag after interrupt
// RULE6 - selector codes 0 to 14 pick pins
// RULE7 - code 15 pin fifteen, 31 quarter supply
// RULE8 - twelve-bit results, seventeen channels in total
// RULE9 - one internal channel measures quarter supply
// RULE10 - reference from supply or three internal levels
// RULE11 - reference codes: supply, 1.024, 2.4, 2.048
// RULE12 - converter clock derived from system clock
// RULE13 - full sequence is sampling plus conversion
// RULE14 - sample 6 or 36 clocks, convert 14
// RULE15 - divider codes give 16, 12, 6, 4
// RULE16 - result latched with the done flag
// RULE17 - software powers and selects before triggering
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "sadc_defs.svh"

module sadc_top
    import sadc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic afe_compare,
    output logic afe_power,
    output logic [16:0] afe_input_select,
    output logic [1:0] afe_reference_select,
    output logic afe_sample,
    output logic [11:0] afe_dac_code,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] sadc_divisor(input logic [1:0] code);
        case (code)
            2'b00: sadc_divisor = `SADC_DIV_CODE0;
            2'b01: sadc_divisor = `SADC_DIV_CODE1;
            2'b10: sadc_divisor = `SADC_DIV_CODE2;
            default: sadc_divisor = `SADC_DIV_CODE3;
        endcase
    endfunction : sadc_divisor

    function automatic logic sadc_hit(input logic [31:0] addr, input logic [7:0] idx);
        sadc_hit = (addr[31:10] == 22'h000000) && (addr[9:2] == idx);
    endfunction : sadc_hit

    ////////////////////////////////////////////////////////////////////////
    // bus state
    logic wr_pend;
    logic [31:0] wr_addr;
    logic rd_pend;
    logic [31:0] rd_addr;
    logic next_wr_pend;
    logic [31:0] next_wr_addr;
    logic next_rd_pend;
    logic [31:0] next_rd_addr;
    logic next_hreadyout;
    logic [31:0] next_hrdata;
    logic accept;

    // register state
    logic power;
    logic [4:0] chan;
    logic done;
    logic [1:0] div_code;
    logic long_sample;
    logic [1:0] ref_sel;
    logic [11:0] result;
    logic status;
    logic mask;
    logic next_power;
    logic [4:0] next_chan;
    logic next_done;
    logic [1:0] next_div_code;
    logic next_long_sample;
    logic [1:0] next_ref_sel;
    logic [11:0] next_result;
    logic next_status;
    logic next_mask;
    logic [16:0] next_input_select;
    logic ctl_write;
    logic cfg_write;
    logic trigger;

    // conversion state
    sadc_state_t state;
    sadc_state_t next_state;
    logic [4:0] div_cnt;
    logic [5:0] phase_cnt;
    logic [11:0] next_dac_code;
    logic [4:0] next_div_cnt;
    logic [5:0] next_phase_cnt;
    logic tick;
    logic finish;
    logic [3:0] bidx;
    logic cmp_s1;
    logic cmp_s2;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: writes take no wait, reads take one so a write just before is seen
    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        next_wr_pend = accept && hwrite;
        next_wr_addr = accept ? haddr : wr_addr;
        next_rd_pend = accept && !hwrite;
        next_rd_addr = accept ? haddr : rd_addr;
        next_hreadyout = !next_rd_pend;
        next_hrdata = hrdata;
        if (rd_pend) begin
            next_hrdata = 32'h00000000;
            if (sadc_hit(rd_addr, `SADC_IDX_CONTROL)) begin
                // trigger reads back as zero, it holds no state [RULE2]
                next_hrdata[7:0] = {power, 1'b0, done, chan};
            end else if (sadc_hit(rd_addr, `SADC_IDX_CONFIG)) begin
                next_hrdata[7:0] = {ref_sel, 3'b000, long_sample, div_code};
            end else if (sadc_hit(rd_addr, `SADC_IDX_RESULT)) begin
                next_hrdata[11:0] = result;
            end else if (sadc_hit(rd_addr, `SADC_IDX_STATUS)) begin
                next_hrdata[`SADC_ST_DONE] = status;
            end else if (sadc_hit(rd_addr, `SADC_IDX_MASK)) begin
                next_hrdata[`SADC_ST_DONE] = mask;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h00000000;
            rd_pend <= 1'b0;
            rd_addr <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            rd_pend <= next_rd_pend;
            rd_addr <= next_rd_addr;
            hreadyout <= next_hreadyout;
            hresp <= 1'b0;
            hrdata <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    assign ctl_write = wr_pend && sadc_hit(wr_addr, `SADC_IDX_CONTROL);
    assign cfg_write = wr_pend && sadc_hit(wr_addr, `SADC_IDX_CONFIG);
    // trigger needs power on in the written value; a zero in the bit is inert [RULE2] [RULE17]
    assign trigger = ctl_write && hwdata[`SADC_CTL_TRIGGER] && hwdata[`SADC_CTL_POWER];

    always_comb begin
        next_power = power;
        next_chan = chan;
        next_done = done;
        next_div_code = div_code;
        next_long_sample = long_sample;
        next_ref_sel = ref_sel;
        next_result = result;
        next_status = status;
        next_mask = mask;
        if (ctl_write) begin
            next_power = hwdata[`SADC_CTL_POWER]; // [RULE1]
            next_chan = hwdata[`SADC_CTL_CHAN_LSB +: `SADC_CTL_CHAN_W];
            // software may only clear the flag, writing one leaves it [RULE5]
            if (!hwdata[`SADC_CTL_DONE]) begin
                next_done = 1'b0;
            end
        end
        if (trigger) begin
            next_done = 1'b0; // [RULE3]
        end
        if (cfg_write) begin
            next_div_code = hwdata[`SADC_CFG_DIV_LSB +: 2];
            next_long_sample = hwdata[`SADC_CFG_LONG];
            next_ref_sel = hwdata[`SADC_CFG_REF_LSB +: 2]; // [RULE10] [RULE11]
        end
        if (wr_pend && sadc_hit(wr_addr, `SADC_IDX_MASK)) begin
            next_mask = hwdata[`SADC_ST_DONE];
        end
        // reading status clears it
        if (rd_pend && sadc_hit(rd_addr, `SADC_IDX_STATUS)) begin
            next_status = 1'b0;
        end
        // completion wins over any clear in the same cycle
        if (finish) begin
            next_done = 1'b1; // [RULE4]
            next_status = 1'b1;
            next_result = afe_dac_code; // [RULE16] [RULE8]
        end
        // one-hot routing; reserved codes route nothing [RULE6] [RULE7] [RULE9]
        next_input_select = 17'h00000;
        if (next_chan <= `SADC_CHAN_LAST_PIN) begin
            next_input_select[next_chan[3:0]] = 1'b1;
        end else if (next_chan == `SADC_CHAN_QUARTER) begin
            next_input_select[16] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            power <= 1'(`SADC_CTL_RESET >> `SADC_CTL_POWER);
            chan <= 5'h00;
            done <= 1'b0;
            div_code <= 2'h0;
            long_sample <= 1'b0;
            ref_sel <= 2'h0;
            result <= 12'h000;
            status <= 1'b0;
            mask <= `SADC_MASK_RESET;
            afe_power <= 1'b0;
            afe_input_select <= 17'h00001;
            afe_reference_select <= 2'h0;
            irq <= 1'b0;
        end else begin
            power <= next_power;
            chan <= next_chan;
            done <= next_done;
            div_code <= next_div_code;
            long_sample <= next_long_sample;
            ref_sel <= next_ref_sel;
            result <= next_result;
            status <= next_status;
            mask <= next_mask;
            afe_power <= next_power; // [RULE1]
            afe_input_select <= next_input_select;
            afe_reference_select <= next_ref_sel; // [RULE11]
            irq <= next_status && next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparator comes from the analog side, so it is synchronised
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end else begin
            cmp_s1 <= afe_compare;
            cmp_s2 <= cmp_s1;
        end
    end

    // converter clock is a tick of the system clock; divisor of 4 leaves room for the sync delay
    assign tick = (state != SADC_IDLE) && (div_cnt == 5'(sadc_divisor(div_code) - 5'd1)); // [RULE12] [RULE15]
    assign bidx = 4'(6'd12 - phase_cnt);
    assign finish = (state == SADC_CONVERT) && tick && (phase_cnt == `SADC_CONVERT_CLKS - 6'd1);

    always_comb begin
        next_state = state;
        next_div_cnt = tick ? 5'd0 : 5'(div_cnt + 5'd1);
        next_phase_cnt = phase_cnt;
        next_dac_code = afe_dac_code;
        case (state)
            SADC_IDLE: begin
                next_div_cnt = 5'd0;
            end
            SADC_SAMPLE: begin
                if (tick) begin
                    next_phase_cnt = 6'(phase_cnt + 6'd1);
                    // sample length picked by the long select [RULE14] [RULE13]
                    if (phase_cnt == 6'((long_sample ? `SADC_SAMPLE_LONG : `SADC_SAMPLE_SHORT) - 6'd1)) begin
                        next_state = SADC_CONVERT;
                        next_phase_cnt = 6'd0;
                        next_dac_code = 12'h800;
                    end
                end
            end
            SADC_CONVERT: begin
                if (tick) begin
                    next_phase_cnt = 6'(phase_cnt + 6'd1);
                    // clocks 1..12 decide one bit each, msb first [RULE8]
                    if (phase_cnt >= 6'd1 && phase_cnt <= 6'd12) begin
                        if (!cmp_s2) begin
                            next_dac_code[bidx] = 1'b0;
                        end
                        if (bidx != 4'd0) begin
                            next_dac_code[4'(bidx - 4'd1)] = 1'b1;
                        end
                    end
                    if (finish) begin
                        next_state = SADC_IDLE; // [RULE14]
                        next_phase_cnt = 6'd0;
                    end
                end
            end
            default: begin
                next_state = SADC_IDLE;
            end
        endcase
        // a new trigger restarts, power off abandons the conversion
        if (trigger) begin
            next_state = SADC_SAMPLE; // [RULE2]
            next_phase_cnt = 6'd0;
            next_div_cnt = 5'd0;
        end
        if (!next_power) begin
            next_state = SADC_IDLE; // [RULE1]
            next_phase_cnt = 6'd0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= SADC_IDLE;
            div_cnt <= 5'd0;
            phase_cnt <= 6'd0;
            afe_dac_code <= 12'h000;
            afe_sample <= 1'b0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            phase_cnt <= next_phase_cnt;
            afe_dac_code <= next_dac_code;
            afe_sample <= (next_state == SADC_SAMPLE);
        end
    end

endmodule : sadc_top
